// ### bench/quad_source.sv
// quadrature phase source standing in for an encoder or a hand pulser
`timescale 1ns/1ps
module quad_source
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic step,
	input wire logic fwd,
	output logic phase_a,
	output logic phase_b
);
	logic [1:0] pos_ff;

	// one phase edge per step; gray order so a single phase moves at a time
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pos_ff <= 2'h0;
		else if (step)
			pos_ff <= fwd ? pos_ff + 2'h1 : pos_ff - 2'h1;
	end

	// phases are seen as async by the block, so no alignment is promised
	assign phase_a = pos_ff[1];
	assign phase_b = pos_ff[1] ^ pos_ff[0];
endmodule // quad_source

// ### bench/testbench.sv
// self-checking bench for the axis counters and stop interrupt
`timescale 1ns/1ps
module testbench;
	import axis_ctr_pkg::*;
	localparam logic [31:0] CARD = 32'h1 << CTRL_CARD_IRQ;
	localparam logic [31:0] EN = 32'h1 << CTRL_STOP_EN;
	localparam logic [31:0] FO = 32'h1 << CTRL_FINAL_ONLY;
	localparam logic [31:0] STOPB = 32'h1 << EVT_AXIS_STOP;
	localparam logic [31:0] DONEL = 32'h1 << EVT_NORMAL_STOP;
	localparam logic [31:0] DONEN = 32'h1 << EVT_NEXT_CMD;
	// host-side move ratio, raw counts per user unit
	localparam logic [31:0] MOVE_RATIO = 32'h2;
	logic [31:0] tgt;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic [ADDR_W-1:0] adr = '0;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = '0, dat_o, rd;
	logic enc_step = 1'b0, pls_step = 1'b0, enc_fwd = 1'b1, enc_a, enc_b, pls_a, pls_b;
	step_s cmd_step = '0;
	motion_evt_s motion = '0;
	int n_fail = 0, num_checks = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	axis_counters DUT (.CLK(clk), .ARST_N(arst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .ENC_A(enc_a),
		.ENC_B(enc_b), .PLS_A(pls_a), .PLS_B(pls_b), .CMD_STEP(cmd_step), .MOTION(motion),
		.IRQ(irq));
	quad_source enc (.clk(clk), .arst_n(arst_n), .step(enc_step), .fwd(enc_fwd),
		.phase_a(enc_a), .phase_b(enc_b));
	quad_source pls (.clk(clk), .arst_n(arst_n), .step(pls_step), .fwd(enc_fwd),
		.phase_a(pls_a), .phase_b(pls_b));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic end_of_test();
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// classic single cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		if (i == 20)
		begin
			n_fail++;
			end_of_test();
		end
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic cmd(input logic up, input int n);
		repeat (n)
		begin
			@(posedge clk);
			cmd_step <= '{up: up, dn: !up};
		end
		@(posedge clk);
		cmd_step <= '0;
	endtask

	// one quadrature edge, then time for the input synchroniser
	task automatic quad(input logic pulser, input logic fwd);
		@(posedge clk);
		enc_fwd <= fwd;
		enc_step <= !pulser;
		pls_step <= pulser;
		@(posedge clk);
		enc_step <= 1'b0;
		pls_step <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	task automatic mot(input logic on, input logic last, input logic err);
		@(posedge clk);
		motion <= '{start: 1'b1, stop_int_on: on, default: '0};
		@(posedge clk);
		motion <= '{done: !err, last: last, err_stop: err, err_factor: 18'h5, default: '0};
		@(posedge clk);
		motion <= '0;
		repeat (3) @(posedge clk);
	endtask

	// cause word read, read-clear, then status cleared and irq dropped
	task automatic ev(input logic [31:0] exp, input logic exp_irq);
		chk({31'h0, irq}, {31'h0, exp_irq});
		rdchk(OFS_EVT_CAUSE, exp);
		rdchk(OFS_EVT_CAUSE, 32'h0);
		wb(1'b1, OFS_IRQ_STATUS, 32'h3);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rdchk(OFS_CTRL, CTRL_RESET);
		rdchk(OFS_FB_POS, CNT_RESET);
		rdchk(OFS_CMD_POS, CNT_RESET);
		rdchk(OFS_ERR_CNT, CNT_RESET);
		rdchk(OFS_IRQ_MASK, 32'h0);
		rdchk(8'h40, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_count();
		wb(1'b1, OFS_CMD_POS, 32'h10);
		wb(1'b1, OFS_ERR_CNT, 32'h0);
		cmd(1'b1, 3);
		cmd(1'b0, 1);
		tgt = 32'h10 + 32'h3 - 32'h1;
		rdchk(OFS_CMD_POS, tgt);
		rdchk(OFS_ERR_CNT, 32'h2);
		sel <= 4'h1;
		wb(1'b1, OFS_CMD_POS, 32'haaaa_aa33);
		sel <= 4'hf;
		rdchk(OFS_CMD_POS, 32'h33);
		wb(1'b1, OFS_ERR_CNT, 32'h0);
		rdchk(OFS_ERR_CNT, 32'h0);
		cmd(1'b0, 1);
		rdchk(OFS_ERR_CNT, 32'hffff_ffff);
		wb(1'b1, OFS_ERR_CNT, 32'h0);
		cmd(1'b1, 32770);
		rdchk(OFS_ERR_CNT, {16'h0, ERR_MAX});
		wb(1'b1, OFS_ERR_CNT, 32'h0);
		wb(1'b1, OFS_FB_POS, 32'h0);
		quad(1'b0, 1'b1);
		wb(1'b0, OFS_FB_POS, 32'h0);
		chk({31'h0, rd == 32'h1 || rd == 32'hffff_ffff}, 32'h1);
		quad(1'b0, 1'b0);
		rdchk(OFS_FB_POS, 32'h0);
		wb(1'b1, OFS_CTRL, CTRL_RESET | (32'h1 << CTRL_FB_SRC));
		wb(1'b1, OFS_FB_POS, 32'h3 * MOVE_RATIO);
		wb(1'b1, OFS_ERR_CNT, 32'h0);
		cmd(1'b1, 2);
		rdchk(OFS_FB_POS, 32'h8);
		chk(rd / MOVE_RATIO, 32'h4);
		rdchk(OFS_ERR_CNT, 32'h0);
	endtask

	// every source code; only the selected source may move the count
	task automatic t_gp();
		logic [31:0] v;
		for (int c = 0; c < 4; c++)
		begin
			wb(1'b1, OFS_CTRL, 32'(c) << CTRL_GP_SRC_LO);
			wb(1'b1, OFS_GP_CNT, 32'h0);
			cmd(1'b1, 2);
			quad(1'b0, 1'b1);
			quad(1'b1, 1'b1);
			wb(1'b0, OFS_GP_CNT, 32'h0);
			v = rd;
			case (c)
				0: chk(v, 32'h2);
				1, 2: chk({31'h0, v == 32'h1 || v == 32'hffff_ffff}, 32'h1);
				default: chk({31'h0, v > 32'h8 && v < 32'h40}, 32'h1);
			endcase
		end
	endtask

	task automatic t_irq();
		wb(1'b1, OFS_IRQ_MASK, 32'h1 << IRQ_STOP);
		wb(1'b1, OFS_CTRL, CARD);
		mot(1'b1, 1'b1, 1'b0);
		ev(DONEL, 1'b0);
		wb(1'b1, OFS_CTRL, CARD | EN);
		mot(1'b1, 1'b0, 1'b0);
		ev(STOPB | DONEN, 1'b1);
		mot(1'b0, 1'b1, 1'b0);
		ev(DONEL, 1'b0);
		wb(1'b1, OFS_CTRL, CARD | EN | FO);
		mot(1'b1, 1'b0, 1'b0);
		ev(DONEN, 1'b0);
		mot(1'b1, 1'b1, 1'b0);
		ev(STOPB | DONEL, 1'b1);
		mot(1'b1, 1'b0, 1'b1);
		rdchk(OFS_ERR_CAUSE, 32'h5);
		rdchk(OFS_IRQ_STATUS, 32'h3);
		ev(STOPB, 1'b1);
		rdchk(OFS_ERR_CAUSE, 32'h0);
		wb(1'b1, OFS_CTRL, EN);
		mot(1'b1, 1'b1, 1'b0);
		ev(STOPB | DONEL, 1'b0);
		wb(1'b1, OFS_IRQ_MASK, 32'h0);
		wb(1'b1, OFS_CTRL, CARD | EN);
		mot(1'b1, 1'b1, 1'b0);
		rdchk(OFS_IRQ_STATUS, 32'h1 << IRQ_STOP);
		ev(STOPB | DONEL, 1'b0);
	endtask

	// reset held five cycles, then the scenarios in turn
	initial
	begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_count();
		t_gp();
		t_irq();
		end_of_test();
	end
endmodule // testbench

// ### logic/axis_counters.sv
// per-axis position counters and axis-stop interrupt with a wishbone register file
// Function
// - enabled stop interrupt fires on both normal and error stops
// - per-axis stop interrupt enable, 0 off and 1 on
// - final-only set: interrupt only when last queued command completes
// - final-only clear: interrupt on every command completion
// - stop interrupt reported in bit 31 of event cause word
// - stop interrupt switchable with each motion command
// - reading a cause word clears it to zero
// - feedback counter source: encoder phases or own command pulses
// - command counter counts pulses sent to the driver
// - host can load the feedback counter
// - host can load the command counter
// - error counter readable, cleared on host request
// - general counter readable, loadable, source selectable, pulser after reset
// - general source codes: 0 command, 1 encoder, 2 pulser, 3 clock/2
// - error counter is signed 16 bits, -32768 to 32767
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module axis_counters
	import axis_ctr_pkg::*;
(
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [axis_ctr_pkg::ADDR_W-1:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic ENC_A,
	input wire logic ENC_B,
	input wire logic PLS_A,
	input wire logic PLS_B,
	input axis_ctr_pkg::step_s CMD_STEP,
	input axis_ctr_pkg::motion_evt_s MOTION,
	output logic IRQ
);

	// ****************************************
	// declarations
	// ****************************************
	logic ack_ff;
	logic [31:0] dat_ff;
	logic irq_ff;
	logic [31:0] ctrl_ff;
	logic [31:0] fb_pos_ff;
	logic [31:0] cmd_pos_ff;
	logic signed [ERR_W-1:0] err_cnt_ff;
	logic [31:0] gp_cnt_ff;
	logic [ERR_FACTOR_W-1:0] err_cause_ff;
	logic [31:0] evt_cause_ff;
	logic [IRQ_W-1:0] irq_status_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic cmd_int_on_ff;
	logic half_clk_ff;
	logic acc;
	logic wr;
	logic rd;
	logic [31:0] wdat;
	step_s enc_step;
	step_s pls_step;
	step_s fb_step;
	step_s gp_step;
	logic stop_en;
	logic final_only;
	logic done_irq;
	logic err_irq;
	logic stop_evt;
	logic [31:0] rd_mux;
	logic signed [ERR_W:0] err_sum;
	logic signed [ERR_W:0] err_delta;

	// ****************************************
	// pulse sources
	// ****************************************
	quad_step enc_dec
	(
		.clk(CLK),
		.arst_n(ARST_N),
		.phase_a(ENC_A),
		.phase_b(ENC_B),
		.step(enc_step)
	);

	quad_step pls_dec
	(
		.clk(CLK),
		.arst_n(ARST_N),
		.phase_a(PLS_A),
		.phase_b(PLS_B),
		.step(pls_step)
	);

	// clock/2 enable for the general counter
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			half_clk_ff <= 1'b0;
		else
			half_clk_ff <= ~half_clk_ff;
	end

	// source selection, feedback and general counter
	always_comb
	begin
		fb_step = ctrl_ff[CTRL_FB_SRC] ? CMD_STEP : enc_step;
		case (gp_src_e'(ctrl_ff[CTRL_GP_SRC_HI:CTRL_GP_SRC_LO]))
			GP_CMD: gp_step = CMD_STEP;
			GP_ENC: gp_step = enc_step;
			GP_PLS: gp_step = pls_step;
			GP_CLK2: gp_step = '{up: half_clk_ff, dn: 1'b0};
			default: gp_step = '0;
		endcase
	end

	// ****************************************
	// wishbone slave, one wait state
	// ****************************************
	assign acc = CYC_I & STB_I & ~ack_ff;
	assign wr = acc & WE_I;
	assign rd = acc & ~WE_I;

	// byte lanes merge into the current value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		end
		return res;
	endfunction

	assign wdat = DAT_I;

	// read mux, unmapped addresses read zero
	always_comb
	begin
		case (ADR_I)
			OFS_CTRL: rd_mux = ctrl_ff;
			OFS_FB_POS: rd_mux = fb_pos_ff;
			OFS_CMD_POS: rd_mux = cmd_pos_ff;
			OFS_ERR_CNT: rd_mux = {{(32-ERR_W){err_cnt_ff[ERR_W-1]}}, err_cnt_ff};
			OFS_GP_CNT: rd_mux = gp_cnt_ff;
			OFS_ERR_CAUSE: rd_mux = {{(32-ERR_FACTOR_W){1'b0}}, err_cause_ff};
			OFS_EVT_CAUSE: rd_mux = evt_cause_ff;
			OFS_IRQ_STATUS: rd_mux = {{(32-IRQ_W){1'b0}}, irq_status_ff};
			OFS_IRQ_MASK: rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask_ff};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ack and read data, both registered
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= acc;
			if (rd)
				dat_ff <= rd_mux;
		end
	end

	// control word, only defined bits are kept
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ctrl_ff <= CTRL_RESET;
		else if (wr && ADR_I == OFS_CTRL)
			ctrl_ff <= merge(ctrl_ff, wdat, SEL_I) & CTRL_USED;
	end

	// ****************************************
	// position counters
	// ****************************************
	// a load wins over a step in the same cycle
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			fb_pos_ff <= CNT_RESET;
		else if (wr && ADR_I == OFS_FB_POS)
			fb_pos_ff <= merge(fb_pos_ff, wdat, SEL_I);
		else if (fb_step.up)
			fb_pos_ff <= fb_pos_ff + 32'h1;
		else if (fb_step.dn)
			fb_pos_ff <= fb_pos_ff - 32'h1;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cmd_pos_ff <= CNT_RESET;
		else if (wr && ADR_I == OFS_CMD_POS)
			cmd_pos_ff <= merge(cmd_pos_ff, wdat, SEL_I);
		else if (CMD_STEP.up)
			cmd_pos_ff <= cmd_pos_ff + 32'h1;
		else if (CMD_STEP.dn)
			cmd_pos_ff <= cmd_pos_ff - 32'h1;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			gp_cnt_ff <= CNT_RESET;
		else if (wr && ADR_I == OFS_GP_CNT)
			gp_cnt_ff <= merge(gp_cnt_ff, wdat, SEL_I);
		else if (gp_step.up)
			gp_cnt_ff <= gp_cnt_ff + 32'h1;
		else if (gp_step.dn)
			gp_cnt_ff <= gp_cnt_ff - 32'h1;
	end

	// command minus feedback, saturating rather than wrapping so a runaway
	// axis never looks like a small error
	always_comb
	begin
		err_delta = '0;
		if (CMD_STEP.up)
			err_delta = err_delta + 17'sh1;
		else if (CMD_STEP.dn)
			err_delta = err_delta - 17'sh1;
		if (fb_step.up)
			err_delta = err_delta - 17'sh1;
		else if (fb_step.dn)
			err_delta = err_delta + 17'sh1;
		err_sum = $signed({err_cnt_ff[ERR_W-1], err_cnt_ff}) + err_delta; // a bare concat is unsigned
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			err_cnt_ff <= '0;
		else if (wr && ADR_I == OFS_ERR_CNT)
			err_cnt_ff <= '0;
		else if (err_sum > $signed({ERR_MAX[ERR_W-1], ERR_MAX}))
			err_cnt_ff <= ERR_MAX;
		else if (err_sum < $signed({ERR_MIN[ERR_W-1], ERR_MIN}))
			err_cnt_ff <= ERR_MIN;
		else
			err_cnt_ff <= err_sum[ERR_W-1:0];
	end

	// ****************************************
	// axis-stop interrupt
	// ****************************************
	// per-command switch, latched as each command starts
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cmd_int_on_ff <= 1'b1;
		else if (MOTION.start)
			cmd_int_on_ff <= MOTION.stop_int_on;
	end

	assign stop_en = ctrl_ff[CTRL_STOP_EN] & cmd_int_on_ff;
	assign final_only = ctrl_ff[CTRL_FINAL_ONLY];
	assign done_irq = MOTION.done & stop_en & (~final_only | MOTION.last);
	assign err_irq = MOTION.err_stop & stop_en;
	assign stop_evt = done_irq | err_irq;

	// cause words clear on read, a new event in the same cycle wins
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			evt_cause_ff <= 32'h0000_0000;
			err_cause_ff <= '0;
		end
		else
		begin
			evt_cause_ff <= (rd && ADR_I == OFS_EVT_CAUSE) ? 32'h0000_0000 : evt_cause_ff;
			evt_cause_ff[EVT_AXIS_STOP] <= stop_evt |
				(evt_cause_ff[EVT_AXIS_STOP] & ~(rd && ADR_I == OFS_EVT_CAUSE));
			evt_cause_ff[EVT_NORMAL_STOP] <= (MOTION.done & MOTION.last) |
				(evt_cause_ff[EVT_NORMAL_STOP] & ~(rd && ADR_I == OFS_EVT_CAUSE));
			evt_cause_ff[EVT_NEXT_CMD] <= (MOTION.done & ~MOTION.last) |
				(evt_cause_ff[EVT_NEXT_CMD] & ~(rd && ADR_I == OFS_EVT_CAUSE));
			err_cause_ff <= ((rd && ADR_I == OFS_ERR_CAUSE) ? '0 : err_cause_ff) |
				(MOTION.err_stop ? MOTION.err_factor : '0);
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			irq_status_ff <= '0;
		else
		begin
			irq_status_ff[IRQ_STOP] <= stop_evt | (irq_status_ff[IRQ_STOP] &
				~(wr && ADR_I == OFS_IRQ_STATUS && SEL_I[0] && DAT_I[IRQ_STOP]));
			irq_status_ff[IRQ_ERR] <= MOTION.err_stop | (irq_status_ff[IRQ_ERR] &
				~(wr && ADR_I == OFS_IRQ_STATUS && SEL_I[0] && DAT_I[IRQ_ERR]));
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			irq_mask_ff <= IRQ_MASK_RESET;
		else if (wr && ADR_I == OFS_IRQ_MASK && SEL_I[0])
			irq_mask_ff <= DAT_I[IRQ_W-1:0];
	end

	// level output, gated by the card-wide enable
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			irq_ff <= 1'b0;
		else
			irq_ff <= ctrl_ff[CTRL_CARD_IRQ] & (|(irq_status_ff & irq_mask_ff));
	end

	assign DAT_O = dat_ff;
	assign ACK_O = ack_ff;
	assign IRQ = irq_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	stop_sets_bit_a: assert property (stop_evt |=> evt_cause_ff[EVT_AXIS_STOP])
		else $error("stop event did not set cause bit 31");
	stop_off_quiet_a: assert property (!ctrl_ff[CTRL_STOP_EN] && !evt_cause_ff[EVT_AXIS_STOP]
		|=> !evt_cause_ff[EVT_AXIS_STOP])
		else $error("stop bit set while stop interrupt disabled");
	final_only_a: assert property (MOTION.done && !MOTION.last && !MOTION.err_stop &&
		final_only |-> !stop_evt)
		else $error("intermediate completion raised stop interrupt");
	every_cmd_a: assert property (MOTION.done && ctrl_ff[CTRL_STOP_EN] && cmd_int_on_ff &&
		!final_only |=> evt_cause_ff[EVT_AXIS_STOP] && irq_status_ff[IRQ_STOP])
		else $error("completion missed stop interrupt");
	cause_clear_a: assert property (rd && ADR_I == OFS_EVT_CAUSE && !MOTION.done &&
		!MOTION.err_stop |=> evt_cause_ff == 32'h0000_0000)
		else $error("event cause not cleared by read");
	err_reset_a: assert property (wr && ADR_I == OFS_ERR_CNT |=> err_cnt_ff == '0)
		else $error("error counter not cleared");
	err_sat_a: assert property (err_cnt_ff == ERR_MAX && CMD_STEP.up && !fb_step.up &&
		!fb_step.dn && !wr |=> err_cnt_ff == ERR_MAX)
		else $error("error counter wrapped past maximum");
	cmd_count_a: assert property (CMD_STEP.up && !(wr && ADR_I == OFS_CMD_POS)
		|=> cmd_pos_ff == $past(cmd_pos_ff) + 32'h1)
		else $error("command counter missed a pulse");
	fb_load_a: assert property (wr && ADR_I == OFS_FB_POS && SEL_I == 4'hf
		|=> fb_pos_ff == $past(DAT_I))
		else $error("feedback counter load lost");
	ack_pulse_a: assert property (acc |=> ACK_O ##1 !ACK_O)
		else $error("ack not a single cycle after request");

endmodule // axis_counters

// ### logic/axis_ctr_pkg.sv
// constants, types and register map of the axis counter and stop interrupt block
package axis_ctr_pkg;

	// ****************************************
	// register map (byte addresses, one word each)
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FB_POS = 8'h04;
	localparam logic [7:0] OFS_CMD_POS = 8'h08;
	localparam logic [7:0] OFS_ERR_CNT = 8'h0c;
	localparam logic [7:0] OFS_GP_CNT = 8'h10;
	localparam logic [7:0] OFS_ERR_CAUSE = 8'h14;
	localparam logic [7:0] OFS_EVT_CAUSE = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

	// ****************************************
	// control word fields and reset values
	// ****************************************
	localparam int CTRL_STOP_EN = 0;
	localparam int CTRL_FINAL_ONLY = 1;
	localparam int CTRL_FB_SRC = 2;
	localparam int CTRL_GP_SRC_LO = 4;
	localparam int CTRL_GP_SRC_HI = 5;
	localparam int CTRL_CARD_IRQ = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
	localparam logic [31:0] CTRL_USED = 32'h0000_0137;

	// ****************************************
	// cause words and interrupt status
	// ****************************************
	localparam int EVT_NORMAL_STOP = 0;
	localparam int EVT_NEXT_CMD = 1;
	localparam int EVT_AXIS_STOP = 31;
	localparam int ERR_FACTOR_W = 18;
	localparam int IRQ_W = 2;
	localparam int IRQ_STOP = 0;
	localparam int IRQ_ERR = 1;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

	// ****************************************
	// counters
	// ****************************************
	localparam int ERR_W = 16;
	localparam logic signed [ERR_W-1:0] ERR_MAX = 16'sh7fff;
	localparam logic signed [ERR_W-1:0] ERR_MIN = 16'sh8000;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		GP_CMD = 2'h0,
		GP_ENC = 2'h1,
		GP_PLS = 2'h2,
		GP_CLK2 = 2'h3
	} gp_src_e;

	// one step of a pulse source, up or down
	typedef struct packed
	{
		logic up;
		logic dn;
	} step_s;

	// motion sequencer events for this axis
	typedef struct packed
	{
		logic start;
		logic stop_int_on;
		logic done;
		logic last;
		logic err_stop;
		logic [ERR_FACTOR_W-1:0] err_factor;
	} motion_evt_s;

endpackage

// ### logic/quad_step.sv
// two-phase input synchroniser and x4 quadrature step decoder
`timescale 1ns/1ps
module quad_step
	import axis_ctr_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic phase_a,
	input wire logic phase_b,
	output axis_ctr_pkg::step_s step
);

	logic [1:0] meta_ff;
	logic [1:0] sync_ff;
	logic [1:0] prev_ff;
	step_s step_ff;

	// two flops before any decode, pins are asynchronous
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= 2'h0;
			sync_ff <= 2'h0;
			prev_ff <= 2'h0;
		end
		else
		begin
			meta_ff <= {phase_a, phase_b};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// gray sequence 00-01-11-10 counts up, reverse counts down
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			step_ff <= '0;
		else
		begin
			case ({prev_ff, sync_ff})
				4'h1, 4'h7, 4'he, 4'h8: step_ff <= '{up: 1'b1, dn: 1'b0};
				4'h2, 4'hb, 4'hd, 4'h4: step_ff <= '{up: 1'b0, dn: 1'b1};
				default: step_ff <= '0; // idle or illegal double change
			endcase
		end
	end

	assign step = step_ff;

endmodule // quad_step
